// File: fieldbus_card_status_leds.sv
// indicator drive for a fieldbus card: link, online, offline/fault and power lamps
//
// Contract
// - While the card is still connecting to the control board the link lamp is steadily on.
// - Once the control-board link is up the link lamp blinks with 1s period, 0.5s lit then 0.5s dark.
// - While the card is disconnected from the control board the link lamp is off.
// - While the card is online on the fieldbus the online lamp is steadily on.
// - While the card is not online the online lamp is off.
// - While the card is offline with no fault the offline/fault lamp is steadily on.
// - A configuration length mismatch blinks the offline/fault lamp at 1 Hz.
// - Wrong user parameter data blinks the offline/fault lamp at 2 Hz.
// - A failed protocol chip initialisation blinks the offline/fault lamp at 4 Hz.
// - With the diagnosis function disabled the offline/fault lamp is off.
// - The power lamp is lit once the control board feeds power to the card.
`timescale 1ns/1ps
`include "fieldbus_lamps_map.svh"
`default_nettype none

module fieldbus_card_status_leds
  import fieldbus_lamps_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `LAMPS_SLOT_NS / `LAMPS_CLK_NS
)
(
  input  wire logic        CLK_SYS,          // system clock, 250 MHz
  input  wire logic        SYS_RST,          // synchronous reset, active high
  input  wire logic        WB_CYC_I,         // wishbone cycle
  input  wire logic        WB_STB_I,         // wishbone strobe
  input  wire logic        WB_WE_I,          // wishbone write enable
  input  wire logic [3:0]  WB_ADR_I,         // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,         // wishbone byte lanes
  input  wire logic [31:0] WB_DAT_I,         // wishbone write data
  output logic      [31:0] WB_DAT_O,         // wishbone read data
  output logic             WB_ACK_O,         // wishbone acknowledge
  input  wire logic        LINK_CONNECTING,  // card is establishing the control-board link
  input  wire logic        LINK_READY,       // control-board link properly established
  input  wire logic        BUS_ONLINE,       // online on the fieldbus, data exchange possible
  input  wire logic        CFG_LEN_ERR,      // configuration length differs from network config
  input  wire logic        PRM_DATA_ERR,     // parameter length or content is wrong
  input  wire logic        CHIP_INIT_ERR,    // protocol chip initialisation failed
  input  wire logic        POWER_FED,        // control board supplies card power
  output logic             LINK_STATUS_LAMP, // link status indicator
  output logic             BUS_ONLINE_LAMP,  // bus online indicator
  output logic             OFFLINE_FAULT_LAMP, // offline/fault indicator
  output logic             CARD_POWER_LAMP   // power indicator
);

  localparam int unsigned PHASE_W = $clog2(`LAMPS_SLOTS_PER_S);

  // refused at elaboration: a one-cycle slot would leave the reload with no count
  if (SLOT_CYCLES < 2)
  begin
    $error("SLOT_CYCLES must be at least 2");
  end
  if (`LAMPS_SLOTS_PER_S != 8)
  begin
    $error("blink phase needs eight slots per second");
  end

  // byte-lane merge, shared by every writable register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[8*i +: 8] = new_val[8*i +: 8];
    return res;
  endfunction

  // lamp level for a pattern; each blink starts with its lit half
  function automatic logic pat_level(
    input fault_pat_t         pat,
    input logic [PHASE_W-1:0] ph
  );
    logic lvl;
    lvl = 1'b0;
    unique case (pat)
      PAT_OFF:    lvl = 1'b0;
      PAT_STEADY: lvl = 1'b1;
      PAT_1HZ:    lvl = ~ph[2];
      PAT_2HZ:    lvl = ~ph[1];
      PAT_4HZ:    lvl = ~ph[0];
      default:    lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // ---------------- register bus ----------------
  logic [31:0]        ctrl;
  logic [31:0]        prescale;
  logic [31:0]        slot_cnt;
  logic [PHASE_W-1:0] phase;
  logic               ack;
  logic [31:0]        rdata;

  wire        bus_req    = WB_CYC_I & WB_STB_I & ~ack;
  wire        bus_wr     = bus_req & WB_WE_I;
  wire        hit_ctrl   = (WB_ADR_I == `LAMPS_CTRL_OFS);
  wire        hit_pre    = (WB_ADR_I == `LAMPS_PRESCALE_OFS);
  wire        hit_stat   = (WB_ADR_I == `LAMPS_STATUS_OFS);
  wire        diag_en    = ctrl[`LAMPS_CTRL_DIAG_BIT];
  wire [31:0] next_ctrl  = lane_merge(ctrl, WB_DAT_I, WB_SEL_I);
  wire [31:0] next_pre   = lane_merge(prescale, WB_DAT_I, WB_SEL_I);

  fault_pat_t  fault_pat;
  link_state_t link_state;

  wire [3:0] lamps = {CARD_POWER_LAMP, OFFLINE_FAULT_LAMP, BUS_ONLINE_LAMP,
                      LINK_STATUS_LAMP};

  wire [31:0] status_word =
    (32'(lamps) << `LAMPS_STAT_LAMP_LSB) |
    (32'(fault_pat) << `LAMPS_STAT_PAT_LSB) |
    (32'(phase) << `LAMPS_STAT_PHASE_LSB);

  // only the diagnosis enable is writable in ctrl; other bits read zero
  wire [31:0] ctrl_rd = {31'h0, diag_en};

  wire [31:0] read_mux = hit_ctrl ? ctrl_rd :
                         hit_pre  ? prescale :
                         hit_stat ? status_word : 32'h0;

  // one wait state: ack a cycle after the request, dropped the cycle after
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ack <= 1'b0;
    else
      ack <= bus_req;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      rdata <= 32'h0;
    else if (bus_req && !WB_WE_I)
      rdata <= read_mux;
  end

  // writes land on the request edge; the request holds until ack anyway
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ctrl <= `LAMPS_CTRL_RST;
    else if (bus_wr && hit_ctrl)
      ctrl <= {31'h0, next_ctrl[`LAMPS_CTRL_DIAG_BIT]};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      prescale <= 32'(SLOT_CYCLES - 1);
    else if (bus_wr && hit_pre)
      prescale <= next_pre;
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdata;

  // ---------------- blink time base ----------------
  // a new prescale value applies at the next reload, so a slot is never cut short
  wire slot_tick = (slot_cnt == 32'h0);

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      slot_cnt <= 32'(SLOT_CYCLES - 1);
    else if (slot_tick)
      slot_cnt <= prescale;
    else
      slot_cnt <= slot_cnt - 32'h1;
  end

  // eight slots of 125 ms make one second; bit 2 is 1 Hz, bit 1 2 Hz, bit 0 4 Hz
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      phase <= '0;
    else if (slot_tick)
      phase <= phase + PHASE_W'(1);
  end

  wire blink_1hz = ~phase[2];

  // ---------------- state selection ----------------
  // link up outranks connecting, so a late connecting flag cannot freeze the lamp on
  assign link_state = LINK_READY      ? LINK_UP :
                      LINK_CONNECTING ? LINK_WAIT :
                      LINK_DOWN;

  wire link_level = (link_state == LINK_UP)   ? blink_1hz :
                    (link_state == LINK_WAIT) ? 1'b1 : 1'b0;

  // diagnosis off masks every fault pattern, steady offline included
  assign fault_pat = !diag_en      ? PAT_OFF :
                     CHIP_INIT_ERR ? PAT_4HZ :
                     PRM_DATA_ERR  ? PAT_2HZ :
                     CFG_LEN_ERR   ? PAT_1HZ :
                     !BUS_ONLINE   ? PAT_STEADY :
                     PAT_OFF;

  wire fault_level = pat_level(fault_pat, phase);

  // ---------------- lamp flip-flops ----------------
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      LINK_STATUS_LAMP   <= 1'b0;
      BUS_ONLINE_LAMP    <= 1'b0;
      OFFLINE_FAULT_LAMP <= 1'b0;
      CARD_POWER_LAMP    <= 1'b0;
    end
    else
    begin
      LINK_STATUS_LAMP   <= link_level;
      BUS_ONLINE_LAMP    <= BUS_ONLINE;
      OFFLINE_FAULT_LAMP <= fault_level;
      CARD_POWER_LAMP    <= POWER_FED;
    end
  end

  // ---------------- assertions ----------------
  sequence s_connecting;
    LINK_CONNECTING && !LINK_READY;
  endsequence

  sequence s_disconnected;
    !LINK_CONNECTING && !LINK_READY;
  endsequence

  sequence s_diag_clean_offline;
    diag_en && !BUS_ONLINE && !CFG_LEN_ERR && !PRM_DATA_ERR && !CHIP_INIT_ERR;
  endsequence

  sequence s_slot_edge;
    slot_tick ##1 !slot_tick;
  endsequence

  property p_link_wait;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_connecting |=> LINK_STATUS_LAMP;
  endproperty
  a_link_wait: assert property (p_link_wait)
    else $error("link lamp not steady on while connecting");

  property p_link_blink;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    LINK_READY |=> (LINK_STATUS_LAMP == ~$past(phase[2]));
  endproperty
  a_link_blink: assert property (p_link_blink)
    else $error("link lamp does not follow the 1 s blink");

  property p_link_off;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_disconnected |=> !LINK_STATUS_LAMP;
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("link lamp lit while disconnected");

  property p_online_on;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    BUS_ONLINE[*2] |-> BUS_ONLINE_LAMP;
  endproperty
  a_online_on: assert property (p_online_on)
    else $error("online lamp dark while online");

  property p_online_off;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !BUS_ONLINE |=> !BUS_ONLINE_LAMP;
  endproperty
  a_online_off: assert property (p_online_off)
    else $error("online lamp lit while not online");

  property p_offline_steady;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_diag_clean_offline |=> OFFLINE_FAULT_LAMP;
  endproperty
  a_offline_steady: assert property (p_offline_steady)
    else $error("offline lamp not steady while offline");

  property p_cfg_1hz;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (diag_en && CFG_LEN_ERR && !PRM_DATA_ERR && !CHIP_INIT_ERR)
      |=> (OFFLINE_FAULT_LAMP == ~$past(phase[2]));
  endproperty
  a_cfg_1hz: assert property (p_cfg_1hz)
    else $error("configuration error not shown at 1 Hz");

  property p_prm_2hz;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (diag_en && PRM_DATA_ERR && !CHIP_INIT_ERR)
      |=> (OFFLINE_FAULT_LAMP == ~$past(phase[1]));
  endproperty
  a_prm_2hz: assert property (p_prm_2hz)
    else $error("parameter error not shown at 2 Hz");

  property p_chip_4hz;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (diag_en && CHIP_INIT_ERR) |=> (OFFLINE_FAULT_LAMP == ~$past(phase[0]));
  endproperty
  a_chip_4hz: assert property (p_chip_4hz)
    else $error("chip init error not shown at 4 Hz");

  property p_diag_off;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !diag_en |=> !OFFLINE_FAULT_LAMP;
  endproperty
  a_diag_off: assert property (p_diag_off)
    else $error("offline lamp lit with diagnosis disabled");

  property p_power;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    POWER_FED |=> CARD_POWER_LAMP;
  endproperty
  a_power: assert property (p_power)
    else $error("power lamp dark while power is fed");

  property p_phase_step;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    slot_tick |=> (phase == $past(phase) + PHASE_W'(1));
  endproperty
  a_phase_step: assert property (p_phase_step)
    else $error("blink phase did not advance on a slot tick");

  property p_phase_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !slot_tick |=> $stable(phase);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("blink phase moved without a slot tick");

  property p_reload;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_slot_edge |-> (slot_cnt == $past(prescale));
  endproperty
  a_reload: assert property (p_reload)
    else $error("prescaler did not reload from its register");

  property p_ack_pulse;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held for more than one cycle");

endmodule

`default_nettype wire

// File: fieldbus_lamps_map.svh
// register offsets, field positions, reset values and timing for the indicator block
`ifndef FIELDBUS_LAMPS_MAP_SVH
`define FIELDBUS_LAMPS_MAP_SVH

`define LAMPS_CTRL_OFS       4'h0
`define LAMPS_PRESCALE_OFS   4'h4
`define LAMPS_STATUS_OFS     4'h8

`define LAMPS_CTRL_DIAG_BIT  0
`define LAMPS_CTRL_RST       32'h0000_0001

`define LAMPS_STAT_LAMP_LSB  0
`define LAMPS_STAT_PAT_LSB   4
`define LAMPS_STAT_PHASE_LSB 12

`define LAMPS_CLK_NS         4
`define LAMPS_SLOT_NS        125000000
`define LAMPS_SLOTS_PER_S    8

`endif

// File: fieldbus_lamps_pkg.sv
// types shared by the fieldbus card indicator block
package fieldbus_lamps_pkg;

  typedef enum logic [4:0] {
    PAT_OFF    = 5'b00001,
    PAT_STEADY = 5'b00010,
    PAT_1HZ    = 5'b00100,
    PAT_2HZ    = 5'b01000,
    PAT_4HZ    = 5'b10000
  } fault_pat_t;

  typedef enum logic [2:0] {
    LINK_DOWN = 3'b001,
    LINK_WAIT = 3'b010,
    LINK_UP   = 3'b100
  } link_state_t;

endpackage

// File: fieldbus_peer_model.sv
// far-side model: control-board link and fieldbus network status levels
`timescale 1ns/1ps
`default_nettype none
module fieldbus_peer_model
(
  input  wire logic       clk,        // system clock
  input  wire logic       rst,        // synchronous reset
  input  wire logic [6:0] req,        // {power,chip,prm,cfg,online,ready,connecting}
  output logic            connecting, // link being set up
  output logic            ready,      // link established
  output logic            online,     // fieldbus online
  output logic            cfg_err,    // configuration length error
  output logic            prm_err,    // parameter data error
  output logic            chip_err,   // protocol chip init failed
  output logic            power       // card powered
);
  // levels change only on the clock, as a synchronised status source would
  always_ff @(posedge clk)
  begin
    if (rst)
      {power, chip_err, prm_err, cfg_err, online, ready, connecting} <= 7'h00;
    else
      {power, chip_err, prm_err, cfg_err, online, ready, connecting} <= req;
  end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the fieldbus card indicator block
`timescale 1ns/1ps
`include "fieldbus_lamps_map.svh"
`default_nettype none
module testbench;
  localparam int SLOT = 4;
  logic        CLK_SYS;
  logic        SYS_RST;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rd;
  logic [6:0]  req;
  logic [6:0]  r;
  logic        diag;
  logic [3:0]  sel;
  logic [3:0]  lanes;
  wire logic [31:0] rd_o;
  wire logic        ack;
  wire logic [3:0]  lamps;
  wire logic [6:0]  st;
  int fail_count;
  int compares;
  int seed;
  int period;
  int cycles = 0;
  logic [6:0] tbl [8] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h10, 7'h20, 7'h7f};

  fieldbus_peer_model i_peer (.clk(CLK_SYS), .rst(SYS_RST), .req(req), .connecting(st[0]),
    .ready(st[1]), .online(st[2]), .cfg_err(st[3]), .prm_err(st[4]), .chip_err(st[5]),
    .power(st[6]));

  fieldbus_card_status_leds #(.SLOT_CYCLES(SLOT)) i_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rd_o), .WB_ACK_O(ack), .LINK_CONNECTING(st[0]),
    .LINK_READY(st[1]), .BUS_ONLINE(st[2]), .CFG_LEN_ERR(st[3]), .PRM_DATA_ERR(st[4]),
    .CHIP_INIT_ERR(st[5]), .POWER_FED(st[6]), .LINK_STATUS_LAMP(lamps[0]),
    .BUS_ONLINE_LAMP(lamps[1]), .OFFLINE_FAULT_LAMP(lamps[2]), .CARD_POWER_LAMP(lamps[3]));

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("Error at %0t: run timed out", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      chk("bus answer", 0, 1);
    rd = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // pattern code: 0 off, 1 steady, 2/3/4 blink with 2/4/8 edges per phase period
  task automatic chk_lamp(input int k, input int code, input int lit, input int tog);
    chk("lamp lit cycles", lit, code == 0 ? 0 : code == 1 ? period : period / 2);
    chk("lamp edges", tog, code < 2 ? 0 : 1 << (code - 1));
  endtask

  // counting over one whole phase period makes the check independent of alignment
  task automatic apply(input logic [6:0] v);
    int lit [4];
    int tog [4];
    logic [3:0] prev;
    int fc;
    @(posedge CLK_SYS);
    req <= v;
    repeat (4) @(posedge CLK_SYS);
    lit = '{0, 0, 0, 0};
    tog = '{0, 0, 0, 0};
    prev = lamps;
    for (int c = 0; c < period; c++)
    begin
      @(posedge CLK_SYS);
      for (int k = 0; k < 4; k++)
      begin
        if (lamps[k] === 1'b1)
          lit[k]++;
        if (lamps[k] !== prev[k])
          tog[k]++;
      end
      prev = lamps;
    end
    fc = !diag ? 0 : v[5] ? 4 : v[4] ? 3 : v[3] ? 2 : !v[2] ? 1 : 0;
    chk_lamp(0, v[1] ? 2 : v[0] ? 1 : 0, lit[0], tog[0]);
    chk_lamp(1, v[2] ? 1 : 0, lit[1], tog[1]);
    chk_lamp(2, fc, lit[2], tog[2]);
    chk_lamp(3, v[6] ? 1 : 0, lit[3], tog[3]);
    wb(1'b0, `LAMPS_STATUS_OFS, 32'h0);
    chk_word("status fields", rd & 32'h1fa,
      (32'h1 << (fc + 4)) | {28'h0, v[6], 1'b0, v[2], 1'b0});
    $display("test pattern %h done", v);
  endtask

  initial
  begin
    seed = 53;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hf;
    lanes = 4'hf;
    adr = 4'h0;
    wdat = 32'h0;
    req = 7'h00;
    diag = 1'b1;
    period = 8 * SLOT;
    SYS_RST = 1'b1;
    repeat (6) @(posedge CLK_SYS);
    chk_word("lamps in reset", {28'h0, lamps}, 32'h0);
    SYS_RST <= 1'b0;
    wb(1'b0, `LAMPS_CTRL_OFS, 32'h0);
    chk_word("ctrl reset", rd, `LAMPS_CTRL_RST);
    wb(1'b0, `LAMPS_PRESCALE_OFS, 32'h0);
    chk_word("prescale reset", rd, 32'(SLOT - 1));
    lanes = 4'h1;
    wb(1'b1, `LAMPS_PRESCALE_OFS, 32'hffff_ff05);
    lanes = 4'hf;
    wb(1'b0, `LAMPS_PRESCALE_OFS, 32'h0);
    chk_word("prescale lane write", rd, 32'h5);
    wb(1'b1, `LAMPS_PRESCALE_OFS, 32'(SLOT - 1));
    wb(1'b1, 4'hc, 32'hffff_ffff);
    wb(1'b0, 4'hc, 32'h0);
    chk_word("unmapped read", rd, 32'h0);
    wb(1'b1, `LAMPS_STATUS_OFS, 32'hffff_ffff);
    wb(1'b1, `LAMPS_CTRL_OFS, 32'hffff_fffe);
    wb(1'b0, `LAMPS_CTRL_OFS, 32'h0);
    chk_word("ctrl diag off", rd, 32'h0);
    diag = 1'b0;
    apply(7'h38);
    apply(7'h00);
    wb(1'b1, `LAMPS_CTRL_OFS, 32'h1);
    diag = 1'b1;
    $display("test registers done");
    for (int i = 0; i < 8; i++)
      apply(tbl[i]);
    for (int i = 0; i < 10; i++)
    begin
      r = 7'($random(seed));
      apply(r);
    end
    wb(1'b1, `LAMPS_PRESCALE_OFS, 32'h1);
    repeat (80) @(posedge CLK_SYS);
    period = 16;
    apply(7'h0a);
    apply(7'h32);
    wb(1'b1, `LAMPS_CTRL_OFS, 32'h0);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk_word("lamps in mid-run reset", {28'h0, lamps}, 32'h0);
    SYS_RST <= 1'b0;
    wb(1'b0, `LAMPS_PRESCALE_OFS, 32'h0);
    chk_word("prescale after reset", rd, 32'(SLOT - 1));
    wb(1'b0, `LAMPS_CTRL_OFS, 32'h0);
    chk_word("ctrl after reset", rd, `LAMPS_CTRL_RST);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
`default_nettype wire
